// ==== core/access_phase_seq.sv ====
`timescale 1ns/10ps
module access_phase_seq (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic sync_clr,
   strobe_timing_if.seq tif
);

   area_ctrl_pkg::phase_t phase_q;
   logic [1:0] hold_q;
   logic [1:0] cnt_q;

   // ----------------------------------------
   // Phase sequencing
   // ----------------------------------------
   // Setup adds one cycle, strobe waits for the engine, hold counts down
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_q <= area_ctrl_pkg::PH_IDLE;
         hold_q <= 2'h0;
         cnt_q <= 2'h0;
      end else if (sync_clr) begin
         phase_q <= area_ctrl_pkg::PH_IDLE;
         cnt_q <= 2'h0;
      end else begin
         case (phase_q)
            area_ctrl_pkg::PH_IDLE: begin
               if (tif.start) begin
                  hold_q <= tif.hold_cnt;
                  if (tif.setup_en) begin
                     phase_q <= area_ctrl_pkg::PH_SETUP;
                  end else begin
                     phase_q <= area_ctrl_pkg::PH_STROBE;
                  end
               end
            end
            area_ctrl_pkg::PH_SETUP: begin
               phase_q <= area_ctrl_pkg::PH_STROBE;
            end
            area_ctrl_pkg::PH_STROBE: begin
               // Strobe negated (write) or data sampled (read)
               if (tif.strobe_end) begin
                  if (hold_q == 2'h0) begin
                     phase_q <= area_ctrl_pkg::PH_IDLE;
                  end else begin
                     phase_q <= area_ctrl_pkg::PH_HOLD;
                     cnt_q <= hold_q - 2'h1;
                  end
               end
            end
            area_ctrl_pkg::PH_HOLD: begin
               if (cnt_q == 2'h0) begin
                  phase_q <= area_ctrl_pkg::PH_IDLE;
               end else begin
                  cnt_q <= cnt_q - 2'h1;
               end
            end
            default: begin
               phase_q <= area_ctrl_pkg::PH_IDLE;
            end
         endcase
      end
   end

   // Status towards the control side
   assign tif.phase = phase_q;
   assign tif.busy = (phase_q != area_ctrl_pkg::PH_IDLE);
   assign tif.strobe_allow = (phase_q == area_ctrl_pkg::PH_STROBE);
   assign tif.hold_active = (phase_q == area_ctrl_pkg::PH_HOLD);
   assign tif.done = ((phase_q == area_ctrl_pkg::PH_STROBE) && tif.strobe_end
                      && (hold_q == 2'h0))
                     || ((phase_q == area_ctrl_pkg::PH_HOLD) && (cnt_q == 2'h0));

endmodule // access_phase_seq

// ==== core/area_ctrl_defs.svh ====
`ifndef AREA_CTRL_DEFS_SVH
`define AREA_CTRL_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define AREA_TIMING_OFFSET 12'h000
`define DRAM_CTRL_OFFSET 12'h004
`define CTRL_STATUS_OFFSET 12'h008

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define AREA_TIMING_RESET 32'h07777777
`define AREA_TIMING_WMASK 32'h07777777
`define DRAM_CTRL_RESET 32'h00000000
`define DRAM_CTRL_WMASK 32'hF8BBFFFF

// ----------------------------------------
// Per-area field layout (area n at 4n+2..4n)
// ----------------------------------------
`define AREA_STRIDE 4
`define AREA_SETUP_POS 2
`define AREA_HOLD_LSB 0
`define AREA_HOLD_W 2

// ----------------------------------------
// Dynamic memory control field positions
// ----------------------------------------
`define ROW_OPEN_POS 31
`define INIT_CMD_POS 30
`define REF_PRE_LSB 27
`define COL_NEG_POS 23
`define ROW_PRE_LSB 19
`define RCD_LSB 16
`define WR_PRE_LSB 13
`define REF_ROW_LSB 10
`define BURST_POS 9
`define BUS_SIZE_LSB 7
`define AMX_EXT_POS 6
`define AMX_SEL_LSB 3
`define REFRESH_EN_POS 2
`define REFRESH_MODE_POS 1
`define EDO_POS 0

// ----------------------------------------
// Status register field positions
// ----------------------------------------
`define STAT_STATE_LSB 0
`define STAT_BUSY_POS 2
`define STAT_PENDING_POS 3
`define STAT_CTRL_SEEN_POS 4

`endif

// ==== core/area_ctrl_pkg.sv ====
package area_ctrl_pkg;

   // Phase of one external static-memory access
   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_SETUP = 2'b01,
      PH_STROBE = 2'b10,
      PH_HOLD = 2'b11
   } phase_t;

   // Register selected by an APB address
   typedef enum logic [1:0] {
      SEL_NONE = 2'b00,
      SEL_TIMING = 2'b01,
      SEL_CTRL = 2'b10,
      SEL_STATUS = 2'b11
   } reg_sel_t;

endpackage

// ==== core/area_strobe_and_dram_ctrl_regs.sv ====
`timescale 1ns/10ps
`include "area_ctrl_defs.svh"

// How it works
// - Area timing register resets to 07777777 at power-on reset.
// - Manual reset and standby leave both registers untouched.
// - Reserved timing bits read zero; writes to them are dropped.
// - Area setup bit set adds one cycle before strobe assertion.
// - Writes get 0 to 3 hold cycles after strobe negation.
// - Reads get the same hold cycles after data sampling.
// - Setup and hold only apply to static-memory or burst-ROM areas.
// - Seven independent setup/hold groups at bits 4n+2 down to 4n.
// - Dynamic memory control register resets to all zeros.
// - Control bit 30 picks precharge-all or mode-register init command.
// - Control fields sit at their fixed positions, reserved bits zero.
module area_strobe_and_dram_ctrl_regs #(
   parameter int NUM_AREAS = 7,
   parameter int ADDR_W = 12
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // System state
   input wire logic manual_rst,
   input wire logic standby,
   // Bus engine side
   input wire logic [NUM_AREAS-1:0] area_static_type,
   input wire logic access_start,
   input wire logic [2:0] access_area,
   input wire logic strobe_end,
   output logic access_accept,
   output logic strobe_allow,
   output logic hold_active,
   output logic access_done,
   output logic applied_setup,
   output logic [1:0] applied_hold,
   // Applied dynamic memory control
   output logic row_open_policy,
   output logic init_command_select,
   output logic [2:0] refresh_end_precharge,
   output logic column_negate_period,
   output logic [2:0] row_precharge_period,
   output logic [1:0] row_to_column_delay,
   output logic [2:0] write_precharge_delay,
   output logic [2:0] refresh_row_period,
   output logic burst_enable,
   output logic [1:0] memory_bus_size,
   output logic addr_mux_extension,
   output logic [2:0] addr_mux_select,
   output logic refresh_enable,
   output logic refresh_mode,
   output logic extended_data_out_select
);

   // ----------------------------------------
   // Parameter checks
   // ----------------------------------------
   // Only seven groups fit below the reserved top bits
   generate
      if ((NUM_AREAS < 1) || (NUM_AREAS > 7)) begin : g_bad_areas
         $error("NUM_AREAS must lie between 1 and 7");
      end
      // Offsets are compared on the low 12 address bits
      if (ADDR_W < 12) begin : g_bad_addr
         $error("ADDR_W too narrow for the register map");
      end
      if (`AREA_HOLD_W != 2) begin : g_bad_hold
         $error("hold field must be two bits wide");
      end
   endgenerate

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   // Map an APB address to a register
   function automatic area_ctrl_pkg::reg_sel_t decode(input logic [ADDR_W-1:0] addr);
      logic [11:0] low;
      low = addr[11:0];
      if (addr != ADDR_W'(low)) begin
         decode = area_ctrl_pkg::SEL_NONE;
      end else if (low == `AREA_TIMING_OFFSET) begin
         decode = area_ctrl_pkg::SEL_TIMING;
      end else if (low == `DRAM_CTRL_OFFSET) begin
         decode = area_ctrl_pkg::SEL_CTRL;
      end else if (low == `CTRL_STATUS_OFFSET) begin
         decode = area_ctrl_pkg::SEL_STATUS;
      end else begin
         decode = area_ctrl_pkg::SEL_NONE;
      end
   endfunction

   // Merge write data by byte strobe, keeping only writable bits
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdata,
                                         input logic [3:0] strb, input logic [31:0] wmask);
      logic [31:0] lanes;
      lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      merge = ((old & ~lanes) | (wdata & lanes)) & wmask;
   endfunction

   // Setup bit of one area, zero for an area that does not exist
   function automatic logic area_setup(input logic [31:0] word, input logic [2:0] area);
      if (32'(area) < NUM_AREAS) begin
         area_setup = word[`AREA_STRIDE * area + `AREA_SETUP_POS];
      end else begin
         area_setup = 1'b0;
      end
   endfunction

   // Hold field of one area, zero for an area that does not exist
   function automatic logic [1:0] area_hold(input logic [31:0] word, input logic [2:0] area);
      if (32'(area) < NUM_AREAS) begin
         area_hold = word[`AREA_STRIDE * area + `AREA_HOLD_LSB +: `AREA_HOLD_W];
      end else begin
         area_hold = 2'h0;
      end
   endfunction

   // Writable mask of the timing register trimmed to the areas present
   function automatic logic [31:0] timing_mask();
      logic [31:0] m;
      m = 32'h00000000;
      for (int i = 0; i < NUM_AREAS; i++) begin
         m[`AREA_STRIDE * i +: 3] = 3'h7;
      end
      timing_mask = m & `AREA_TIMING_WMASK;
   endfunction

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   // Writable timing bits for the areas built
   localparam logic [31:0] TIMING_MASK = timing_mask();

   // Register state and decode nets
   logic [31:0] area_timing_q;
   logic [31:0] dram_ctrl_q;
   logic [31:0] ctrl_applied_q;
   logic [31:0] prdata_q;
   logic [31:0] read_mux;
   logic [31:0] status_word;
   logic pending_q;
   logic ctrl_seen_q;
   logic setup_q;
   logic [1:0] hold_q;
   logic apb_setup;
   logic apb_access;
   logic wr_timing;
   logic wr_ctrl;
   logic start_ok;
   logic area_static;
   area_ctrl_pkg::reg_sel_t sel;

   // Bundle between start logic and sequencer
   strobe_timing_if tif ();

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   // Zero-wait slave; any unmapped access or a write to the read-only status flags an error
   assign sel = decode(paddr);
   assign apb_setup = psel && !penable;
   assign apb_access = psel && penable;
   assign pready = 1'b1;
   assign pslverr = apb_access && ((sel == area_ctrl_pkg::SEL_NONE)
                    || (pwrite && (sel == area_ctrl_pkg::SEL_STATUS)));
   assign wr_timing = apb_access && pwrite && (sel == area_ctrl_pkg::SEL_TIMING);
   assign wr_ctrl = apb_access && pwrite && (sel == area_ctrl_pkg::SEL_CTRL);

   // ----------------------------------------
   // Area setup/hold timing register
   // ----------------------------------------
   // Only power-on reset loads its reset value; manual reset and standby do not reach it
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         area_timing_q <= `AREA_TIMING_RESET & TIMING_MASK;
      end else if (wr_timing) begin
         area_timing_q <= merge(area_timing_q, pwdata, pstrb, TIMING_MASK);
      end
   end

   // ----------------------------------------
   // Dynamic memory control register
   // ----------------------------------------
   // Reserved bits 26..24, 22 and 18 never store a one
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         dram_ctrl_q <= `DRAM_CTRL_RESET;
      end else if (wr_ctrl) begin
         dram_ctrl_q <= merge(dram_ctrl_q, pwdata, pstrb, `DRAM_CTRL_WMASK);
      end
   end

   // Remembers that software has written the control word since power-on
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_seen_q <= 1'b0;
      end else if (wr_ctrl) begin
         ctrl_seen_q <= 1'b1;
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   // Status shows the live access phase and pending values
   always_comb begin
      status_word = 32'h00000000;
      status_word[`STAT_STATE_LSB +: 2] = tif.phase;
      status_word[`STAT_BUSY_POS] = tif.busy;
      status_word[`STAT_PENDING_POS] = pending_q;
      status_word[`STAT_CTRL_SEEN_POS] = ctrl_seen_q;
   end

   // Register read multiplexer
   always_comb begin
      case (sel)
         area_ctrl_pkg::SEL_TIMING: read_mux = area_timing_q;
         area_ctrl_pkg::SEL_CTRL: read_mux = dram_ctrl_q;
         area_ctrl_pkg::SEL_STATUS: read_mux = status_word;
         default: read_mux = 32'h00000000;
      endcase
   end

   // Read data captured in the setup phase, stable through the access phase
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata_q <= 32'h00000000;
      end else if (apb_setup && !pwrite) begin
         prdata_q <= read_mux;
      end
   end

   // Read data leaves straight from its register
   assign prdata = prdata_q;

   // ----------------------------------------
   // Access start and value application
   // ----------------------------------------
   // A start is taken only while idle, out of standby and manual reset
   assign start_ok = access_start && !tif.busy && !standby && !manual_rst;
   assign access_accept = start_ok;

   // Setup and hold count only for static-memory or burst-ROM areas
   assign area_static = (32'(access_area) < NUM_AREAS)
                        && area_static_type[access_area[$clog2(NUM_AREAS+1)-1:0]];

   // Request and timing values for the sequencer
   assign tif.start = start_ok;
   assign tif.setup_en = area_static && area_setup(area_timing_q, access_area);
   assign tif.hold_cnt = area_static ? area_hold(area_timing_q, access_area) : 2'h0;
   assign tif.strobe_end = strobe_end;

   // Values in force for the running access
   // They stand until the next accepted start
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         setup_q <= 1'b0;
         hold_q <= 2'h0;
      end else if (start_ok) begin
         setup_q <= tif.setup_en;
         hold_q <= tif.hold_cnt;
      end
   end

   // Control word switches over only at an access start
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_applied_q <= `DRAM_CTRL_RESET;
      end else if (start_ok) begin
         ctrl_applied_q <= dram_ctrl_q;
      end
   end

   // Written but not yet applied; a write wins over a same-cycle apply
   // Shown in the status word
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pending_q <= 1'b0;
      end else if (wr_timing || wr_ctrl) begin
         pending_q <= 1'b1;
      end else if (start_ok) begin
         pending_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // Access phase sequencer
   // ----------------------------------------
   // Manual reset returns the sequencer to idle
   access_phase_seq u_seq (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .sync_clr(manual_rst),
      .tif(tif.seq)
   );

   // Sequencer state and applied values to the pins
   assign strobe_allow = tif.strobe_allow;
   assign hold_active = tif.hold_active;
   assign access_done = tif.done;
   assign applied_setup = setup_q;
   assign applied_hold = hold_q;

   // ----------------------------------------
   // Applied dynamic memory fields
   // ----------------------------------------
   // Copies taken at the last accepted start
   assign row_open_policy = ctrl_applied_q[`ROW_OPEN_POS];
   assign init_command_select = ctrl_applied_q[`INIT_CMD_POS];
   assign refresh_end_precharge = ctrl_applied_q[`REF_PRE_LSB +: 3];
   assign column_negate_period = ctrl_applied_q[`COL_NEG_POS];
   assign row_precharge_period = ctrl_applied_q[`ROW_PRE_LSB +: 3];
   assign row_to_column_delay = ctrl_applied_q[`RCD_LSB +: 2];
   assign write_precharge_delay = ctrl_applied_q[`WR_PRE_LSB +: 3];
   assign refresh_row_period = ctrl_applied_q[`REF_ROW_LSB +: 3];
   assign burst_enable = ctrl_applied_q[`BURST_POS];
   assign memory_bus_size = ctrl_applied_q[`BUS_SIZE_LSB +: 2];
   assign addr_mux_extension = ctrl_applied_q[`AMX_EXT_POS];
   assign addr_mux_select = ctrl_applied_q[`AMX_SEL_LSB +: 3];
   assign extended_data_out_select = ctrl_applied_q[`EDO_POS];

   // Refresh is not tied to an access, so these follow the register directly
   assign refresh_enable = dram_ctrl_q[`REFRESH_EN_POS];
   assign refresh_mode = dram_ctrl_q[`REFRESH_MODE_POS];

endmodule // area_strobe_and_dram_ctrl_regs

// ==== core/strobe_timing_if.sv ====
`timescale 1ns/10ps
interface strobe_timing_if;
   logic start;
   logic setup_en;
   logic [1:0] hold_cnt;
   logic strobe_end;
   logic strobe_allow;
   logic hold_active;
   logic done;
   logic busy;
   area_ctrl_pkg::phase_t phase;

   modport ctrl (
      output start, setup_en, hold_cnt, strobe_end,
      input strobe_allow, hold_active, done, busy, phase
   );
   modport seq (
      input start, setup_en, hold_cnt, strobe_end,
      output strobe_allow, hold_active, done, busy, phase
   );
endinterface // strobe_timing_if

// ==== verif/area_regs_chk.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// Port-level checker
// ----------------------------------------
module area_regs_chk #(
   parameter int NUM_AREAS = 7,
   parameter int ADDR_W = 12
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic manual_rst,
   input wire logic standby,
   input wire logic [NUM_AREAS-1:0] area_static_type,
   input wire logic access_start,
   input wire logic [2:0] access_area,
   input wire logic strobe_end,
   input wire logic access_accept,
   input wire logic strobe_allow,
   input wire logic hold_active,
   input wire logic access_done,
   input wire logic applied_setup,
   input wire logic [1:0] applied_hold,
   input wire logic row_open_policy,
   input wire logic init_command_select,
   input wire logic burst_enable
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   // Steps of one access
   sequence s_setup_taken;
      access_accept ##1 applied_setup;
   endsequence
   sequence s_strobe_end(h);
      strobe_allow && strobe_end && applied_hold == h;
   endsequence

   property p_accept;
      access_accept |-> access_start && !standby && !manual_rst;
   endproperty
   property p_first_cycle;
      access_accept |=> strobe_allow == !applied_setup && !hold_active;
   endproperty
   property p_setup_len;
      s_setup_taken |=> strobe_allow;
   endproperty
   property p_hold3;
      s_strobe_end(2'h3) |=> hold_active [*3] ##1 !hold_active;
   endproperty
   property p_hold1;
      s_strobe_end(2'h1) |=> hold_active && access_done ##1 !hold_active;
   endproperty
   property p_hold0;
      s_strobe_end(2'h0) |-> access_done ##1 (!strobe_allow && !hold_active);
   endproperty
   property p_nonstatic;
      access_accept && access_area < NUM_AREAS && !area_static_type[access_area]
         |=> !applied_setup && applied_hold == 2'h0;
   endproperty
   property p_apply_stable;
      !access_accept |=> $stable({applied_setup, applied_hold, row_open_policy,
         init_command_select, burst_enable});
   endproperty
   property p_unmapped;
      psel && penable && !pwrite && paddr >= 'h00C |-> pslverr && prdata == 32'h0;
   endproperty

   a_accept: assert property (p_accept) else $error("access taken while blocked");
   a_first_cycle: assert property (p_first_cycle) else $error("bad first cycle");
   a_setup_len: assert property (p_setup_len) else $error("setup too long");
   a_hold3: assert property (p_hold3) else $error("hold of three wrong");
   a_hold1: assert property (p_hold1) else $error("hold of one wrong");
   a_hold0: assert property (p_hold0) else $error("hold of zero wrong");
   a_nonstatic: assert property (p_nonstatic) else $error("timing on other type");
   a_apply_stable: assert property (p_apply_stable) else $error("applied mid access");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
   c_done: cover property (access_done);
endmodule // area_regs_chk

bind area_strobe_and_dram_ctrl_regs area_regs_chk #(.NUM_AREAS(NUM_AREAS), .ADDR_W(ADDR_W)) chk_u (
   .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .manual_rst(manual_rst),
   .standby(standby), .area_static_type(area_static_type), .access_start(access_start),
   .access_area(access_area), .strobe_end(strobe_end), .access_accept(access_accept),
   .strobe_allow(strobe_allow), .hold_active(hold_active), .access_done(access_done),
   .applied_setup(applied_setup), .applied_hold(applied_hold),
   .row_open_policy(row_open_policy), .init_command_select(init_command_select),
   .burst_enable(burst_enable));

// ==== verif/area_strobe_and_dram_ctrl_regs_bench.sv ====
`timescale 1ns/10ps
module area_strobe_and_dram_ctrl_regs_bench;
   localparam logic [31:0] TMASK = 32'h07777777;
   localparam logic [31:0] CMASK = 32'hF8BBFFFF;
   logic ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, manual_rst, standby;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, tv, cv, view;
   logic [6:0] area_static_type;
   logic access_start, strobe_end, access_accept, strobe_allow, hold_active, access_done;
   logic [2:0] access_area;
   logic applied_setup, s_exp;
   logic [1:0] applied_hold, h_exp;
   logic row_open_policy, init_command_select, column_negate_period, burst_enable;
   logic addr_mux_extension, refresh_enable, refresh_mode, extended_data_out_select, er;
   logic [2:0] refresh_end_precharge, row_precharge_period, write_precharge_delay;
   logic [2:0] refresh_row_period, addr_mux_select;
   logic [1:0] row_to_column_delay, memory_bus_size;
   int error_cnt = 0;
   int num_checks = 0;
   int lat, dly;

   // ----------------------------------------
   // Design, bus engine model and clock
   // ----------------------------------------
   area_strobe_and_dram_ctrl_regs dut_u (.pstrb(4'hF), .*);
   bus_engine_model eng_u (.ref_clk(ref_clk), .access_accept(access_accept),
      .strobe_allow(strobe_allow), .access_done(access_done),
      .access_start(access_start), .access_area(access_area), .strobe_end(strobe_end));

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // ----------------------------------------
   // Checks and bus cycles
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk); // Idle edge between transfers
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Applied control word seen at the outputs
   function automatic logic [31:0] ctrl_view();
      return {row_open_policy, init_command_select, refresh_end_precharge, 3'h0,
         column_negate_period, 1'b0, row_precharge_period, 1'b0, row_to_column_delay,
         write_precharge_delay, refresh_row_period, burst_enable, memory_bus_size,
         addr_mux_extension, addr_mux_select, refresh_enable, refresh_mode,
         extended_data_out_select};
   endfunction

   // Watchdog against a hang
   initial begin
      #(25 * 8000);
      error_cnt++;
      wrap_up();
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      {psel, penable, pwrite, manual_rst, standby} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      area_static_type = 7'h7F;
      arst_n = 1'b0;
      void'($urandom(51));
      repeat (20) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      rchk(12'h000, 32'h07777777);
      rchk(12'h004, 32'h00000000);
      rchk(12'h00C, 32'h00000000);
      chk(er, 1'b1);
      $display("Test reset values done");
      // One init write before any access: row-open with burst, refresh off
      cv = ($urandom & CMASK & ~32'h6) | 32'hC0000200;
      apb(1'b1, 12'h004, cv);
      rchk(12'h004, cv);
      chk(row_open_policy, 1'b0);
      for (int i = 0; i < 6; i++) begin
         tv = ((i == 0) ? 32'hFFFFFFFF : $urandom) & TMASK;
         apb(1'b1, 12'h000, tv);
         rchk(12'h000, tv);
         rchk(12'h004, cv);
      end
      $display("Test field masks done");
      for (int i = 0; i < 15; i++) begin
         tv = (i == 0) ? 32'h0 : (i == 1) ? TMASK : $urandom & TMASK;
         apb(1'b1, 12'h000, tv);
         area_static_type <= (i < 2) ? 7'h7F : 7'($urandom);
         dly = $urandom % 3;
         @(posedge ref_clk);
         eng_u.run(3'(i % 8), dly, lat);
         s_exp = 1'b0;
         h_exp = 2'h0;
         if (i % 8 < 7 && area_static_type[i % 8]) begin
            s_exp = tv[4 * (i % 8) + 2];
            h_exp = tv[4 * (i % 8) +: 2];
         end
         chk(lat, s_exp + h_exp + dly + 2);
         chk(applied_setup, s_exp);
         chk(applied_hold, h_exp);
      end
      $display("Test access timing done");
      chk(ctrl_view(), cv);
      apb(1'b1, 12'h004, cv | 32'h6);
      chk(refresh_enable, 1'b1);
      rchk(12'h008, 32'h00000018);
      eng_u.run(3'h0, 0, lat);
      view = ctrl_view();
      chk(view, cv | 32'h6);
      rchk(12'h008, 32'h00000010);
      $display("Test control apply done");
      standby <= 1'b1;
      eng_u.run(3'h1, 0, lat);
      chk(lat, -1);
      standby <= 1'b0;
      manual_rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      manual_rst <= 1'b0;
      rchk(12'h000, tv);
      rchk(12'h004, cv | 32'h6);
      $display("Test manual reset and standby done");
      wrap_up();
   end
endmodule // area_strobe_and_dram_ctrl_regs_bench

// ==== verif/bus_engine_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// Bus engine model: issues one access and ends its strobe
// ----------------------------------------
module bus_engine_model (
   input wire logic ref_clk,
   input wire logic access_accept,
   input wire logic strobe_allow,
   input wire logic access_done,
   output logic access_start,
   output logic [2:0] access_area,
   output logic strobe_end
);
   initial begin
      access_start = 1'b0;
      access_area = 3'h0;
      strobe_end = 1'b0;
   end

   // Request held until taken or for 50 cycles; strobe ends dly+1 cycles into the strobe
   task automatic run(input logic [2:0] area, input int dly, output int lat);
      int n;
      int s;
      n = 0;
      s = 0;
      lat = -1;
      access_start <= 1'b1;
      access_area <= area;
      do begin
         @(negedge ref_clk);
         n++;
      end while (!access_accept && n < 50);
      @(posedge ref_clk);
      access_start <= 1'b0;
      access_area <= ~area; // Released, so no stale area remains
      for (int k = 1; k < 60; k++) begin
         @(negedge ref_clk);
         if (access_done) begin
            lat = k;
            break;
         end
         if (strobe_allow) s++;
         @(posedge ref_clk);
         strobe_end <= strobe_allow && s == dly + 1; // Pulse marks strobe negation
      end
      @(posedge ref_clk);
      strobe_end <= 1'b0;
   endtask
endmodule // bus_engine_model
